// >>> hdl/lcm_pkg.sv
/*
  Constants for the secondary-cache and multi-master pin group: mode codes,
  state codes, burst lengths and reset values.
  Assumes a single bus clock; no register bus, configuration arrives as ports.
*/
// Contract
// - burst SRAM: pulse address strobe on new address
// - async SRAM: counter bits on two outputs
// - burst SRAM: advance output steps next beat
// - async SRAM: latch enable captures bus address
// - data chip select during every cache access
// - modified input decoded with programmable polarity
// - mark-modified output driven with programmable polarity
// - data output enable only when RAMs drive
// - three identical write enables during data write
// - hit input decoded with programmable polarity
// - tag output enable when tag drives bus
// - tag valid line driven, programmable polarity
// - tag write enable for tag updates
// - external cache mode repurposes exactly four pins
// - external request answered by address grant
// - separate data grant for external controller
// - external hit: device does not terminate
// - multiprocessor mode repurposes nine pins
// - per-processor request and grants, rest shared
// - processors 1-3 request, get address grant
// - processors 1-3 get own data grant
package lcm_pkg;

  // ----------------------------------------------------------------
  // pin group modes: bit 0 external cache, bit 1 extra processors
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_INT = 2'h0;
  localparam logic [1:0] MODE_EXT = 2'h1;
  localparam logic [1:0] MODE_MP = 2'h2;
  localparam logic [1:0] MODE_MP_EXT = 2'h3;
  localparam int MODE_EXT_BIT = 0;
  localparam int MODE_MP_BIT = 1;

  // ----------------------------------------------------------------
  // burst sequencing
  // ----------------------------------------------------------------
  localparam logic [1:0] BEAT_FIRST = 2'h0;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [1:0] BEAT_STEP = 2'h1;
  localparam int SYNC_WIDTH = 5;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic RST_BIT = 1'h0;
  localparam logic [2:0] RST_TRIPLE = 3'h0;

  // ----------------------------------------------------------------
  // access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ADDR = 3'h2,
    ST_BEAT = 3'h4
  } lcm_state_e;

endpackage : lcm_pkg

// >>> hdl/lcm_sync2.sv
/*
  Two-stage synchroniser for pin inputs, frozen by the clock enable.
  Assumes inputs come from outside the clock domain.
*/
`timescale 1ns/10ps
module lcm_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce) begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : lcm_sync2

// >>> hdl/lcm_pin_group.sv
/*
  Secondary-cache / multi-master pin group: cache SRAM sequencing, tag
  write strobes, and pin repurposing for external cache and extra processors.
  Assumes an outside arbiter chooses grants and an outside controller starts
  cache accesses; every pin output is registered, so pins follow the
  internal state by one clock.
*/
`timescale 1ns/10ps
module lcm_pin_group (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // configuration
  input wire logic [1:0] mode_sel,
  input wire logic sram_is_burst,
  input wire logic pol_dirty_in,
  input wire logic pol_dirty_out,
  input wire logic pol_hit,
  input wire logic pol_tag_valid,
  // cache access requests from the controller core
  input wire logic acc_start,
  input wire logic acc_write,
  input wire logic acc_burst,
  input wire logic tag_read,
  input wire logic tag_update,
  input wire logic tag_set_valid,
  input wire logic tag_set_dirty,
  // grant choices from the arbiter
  input wire logic ext_addr_grant_give,
  input wire logic ext_data_grant_give,
  input wire logic [2:0] cpu_addr_grant_give,
  input wire logic [2:0] cpu_data_grant_give,
  // status to the core
  output logic acc_busy,
  output logic beat_done,
  output logic l2_hit,
  output logic l2_dirty,
  output logic l2_line_valid,
  output logic ext_claim,
  output logic ext_cache_bus_req,
  output logic [2:0] cpu_bus_req,
  // pin SRAM_ADDR_STROBE / ADDR_LATCH_EN / ext request
  output logic strobe_pin_o,
  output logic strobe_pin_oe,
  input wire logic strobe_pin_i,
  // pin counter bit 0 / cpu3 request
  output logic count0_pin_o,
  output logic count0_pin_oe,
  input wire logic count0_pin_i,
  // pin counter bit 1 / advance / ext address grant
  output logic step_pin_o,
  // pin data chip select / cpu3 address grant
  output logic select_pin_o,
  // pin modified in / cpu1 request
  input wire logic dirty_in_pin_i,
  // pin mark modified / cpu1 address grant
  output logic dirty_out_pin_o,
  // pin data output enable / ext data grant
  output logic doe_pin_o,
  // write enables, 0 and 1 double as cpu2 and cpu3 data grants
  output logic [2:0] dwe_pin_o,
  // hit / external hit
  input wire logic hit_pin_i,
  // tag output enable / cpu1 data grant
  output logic toe_pin_o,
  // tag valid / cpu2 request
  output logic tv_pin_o,
  output logic tv_pin_oe,
  input wire logic tv_pin_i,
  // tag write enable / cpu2 address grant
  output logic twe_pin_o
);

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [lcm_pkg::SYNC_WIDTH-1:0] pins_raw;
  logic [lcm_pkg::SYNC_WIDTH-1:0] pins_sync;

  assign pins_raw = {strobe_pin_i, count0_pin_i, dirty_in_pin_i, hit_pin_i, tv_pin_i};

  lcm_sync2 #(
    .WIDTH(lcm_pkg::SYNC_WIDTH)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  wire strobe_s = pins_sync[4];
  wire count0_s = pins_sync[3];
  wire dirty_in_s = pins_sync[2];
  wire hit_s = pins_sync[1];
  wire tv_s = pins_sync[0];

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // mode picks pin roles
  wire mode_ext = mode_sel[lcm_pkg::MODE_EXT_BIT];
  wire mode_mp = mode_sel[lcm_pkg::MODE_MP_BIT];
  wire mode_int = (mode_sel == lcm_pkg::MODE_INT);
  wire int_async = mode_int & ~sram_is_burst;
  wire int_burst = mode_int & sram_is_burst;

  function automatic logic pol_level(input logic active, input logic pol);
    pol_level = pol ? active : ~active;
  endfunction : pol_level

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  lcm_pkg::lcm_state_e state_r;
  lcm_pkg::lcm_state_e state_nxt;
  logic [1:0] beat_r;
  logic [1:0] beat_nxt;
  logic write_r;
  logic burst_r;
  logic tag_wr_r;
  logic tag_valid_r;
  logic tag_dirty_r;

  wire start_ok = (state_r == lcm_pkg::ST_IDLE) & acc_start & mode_int;
  wire last_beat = ~burst_r | (beat_r == lcm_pkg::BEAT_LAST);
  wire in_addr = (state_r == lcm_pkg::ST_ADDR);
  wire in_beat = (state_r == lcm_pkg::ST_BEAT);

  always_comb begin
    state_nxt = state_r;
    beat_nxt = beat_r;
    case (state_r)
      lcm_pkg::ST_IDLE: begin
        if (start_ok) begin
          state_nxt = lcm_pkg::ST_ADDR;
          beat_nxt = lcm_pkg::BEAT_FIRST;
        end
      end
      lcm_pkg::ST_ADDR: begin
        state_nxt = lcm_pkg::ST_BEAT;
      end
      lcm_pkg::ST_BEAT: begin
        if (last_beat) begin
          state_nxt = lcm_pkg::ST_IDLE;
        end else begin
          beat_nxt = 2'(beat_r + lcm_pkg::BEAT_STEP);
        end
      end
      default: begin
        state_nxt = lcm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= lcm_pkg::ST_IDLE;
      beat_r <= lcm_pkg::BEAT_FIRST;
      write_r <= lcm_pkg::RST_BIT;
      burst_r <= lcm_pkg::RST_BIT;
    end else if (ce) begin
      state_r <= state_nxt;
      beat_r <= beat_nxt;
      if (start_ok) begin
        write_r <= acc_write;
        burst_r <= acc_burst;
      end
    end
  end

  // ----------------------------------------------------------------
  // tag write strobe, one cycle per update
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      tag_wr_r <= lcm_pkg::RST_BIT;
      tag_valid_r <= lcm_pkg::RST_BIT;
      tag_dirty_r <= lcm_pkg::RST_BIT;
    end else if (ce) begin
      tag_wr_r <= tag_update & ~mode_mp & ~mode_ext;
      tag_valid_r <= tag_set_valid;
      tag_dirty_r <= tag_set_dirty;
    end
  end

  // ----------------------------------------------------------------
  // internal cache pin functions
  // ----------------------------------------------------------------
  // address strobe pulse
  wire ads_nxt = int_burst & in_addr;
  wire addr_latch_en_nxt = int_async & in_addr;
  wire ba0_nxt = int_async & in_beat & beat_r[0];
  wire ba1_nxt = int_async & in_beat & beat_r[1];
  wire baa_nxt = int_burst & in_beat & ~last_beat;
  wire dcs_nxt = mode_int & (in_addr | in_beat);
  wire doe_nxt = mode_int & in_beat & ~write_r;
  wire dwe_nxt = mode_int & in_beat & write_r;
  wire toe_nxt = mode_int & tag_read & ~tag_wr_r;
  wire twe_nxt = tag_wr_r;
  wire dirty_out_nxt = pol_level(tag_wr_r & tag_dirty_r, pol_dirty_out);
  wire tv_drive_nxt = pol_level(tag_valid_r, pol_tag_valid);

  // ----------------------------------------------------------------
  // pin multiplexing
  // ----------------------------------------------------------------
  // four pins in external mode
  wire strobe_o_nxt = ~mode_ext & (ads_nxt | addr_latch_en_nxt);
  wire strobe_oe_nxt = ~mode_ext;
  wire step_o_nxt = mode_ext ? ext_addr_grant_give : (ba1_nxt | baa_nxt);
  wire doe_o_nxt = mode_ext ? ext_data_grant_give : doe_nxt;
  wire count0_oe_nxt = ~mode_mp;
  wire count0_o_nxt = ~mode_mp & ba0_nxt;
  wire select_o_nxt = mode_mp ? cpu_addr_grant_give[2] : dcs_nxt;
  wire dirty_o_nxt = mode_mp ? cpu_addr_grant_give[0] : dirty_out_nxt;
  wire twe_o_nxt = mode_mp ? cpu_addr_grant_give[1] : twe_nxt;
  wire toe_o_nxt = mode_mp ? cpu_data_grant_give[0] : toe_nxt;
  wire [2:0] dwe_o_nxt = mode_mp ? {dwe_nxt, cpu_data_grant_give[2:1]} : {3{dwe_nxt}};
  // tag valid is driven only while the tag is written
  wire tv_oe_nxt = ~mode_mp & ~mode_ext & tag_wr_r;
  wire tv_o_nxt = tv_oe_nxt & tv_drive_nxt;

  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_pin_o <= lcm_pkg::RST_BIT;
      strobe_pin_oe <= lcm_pkg::RST_BIT;
      count0_pin_o <= lcm_pkg::RST_BIT;
      count0_pin_oe <= lcm_pkg::RST_BIT;
      step_pin_o <= lcm_pkg::RST_BIT;
      select_pin_o <= lcm_pkg::RST_BIT;
      dirty_out_pin_o <= lcm_pkg::RST_BIT;
      doe_pin_o <= lcm_pkg::RST_BIT;
      dwe_pin_o <= lcm_pkg::RST_TRIPLE;
      toe_pin_o <= lcm_pkg::RST_BIT;
      tv_pin_o <= lcm_pkg::RST_BIT;
      tv_pin_oe <= lcm_pkg::RST_BIT;
      twe_pin_o <= lcm_pkg::RST_BIT;
    end else if (ce) begin
      strobe_pin_o <= strobe_o_nxt;
      strobe_pin_oe <= strobe_oe_nxt;
      count0_pin_o <= count0_o_nxt;
      count0_pin_oe <= count0_oe_nxt;
      step_pin_o <= step_o_nxt;
      select_pin_o <= select_o_nxt;
      dirty_out_pin_o <= dirty_o_nxt;
      doe_pin_o <= doe_o_nxt;
      dwe_pin_o <= dwe_o_nxt;
      toe_pin_o <= toe_o_nxt;
      tv_pin_o <= tv_o_nxt;
      tv_pin_oe <= tv_oe_nxt;
      twe_pin_o <= twe_o_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status decode
  // ----------------------------------------------------------------
  // hit with polarity
  wire hit_active = pol_level(hit_s, pol_hit);
  wire dirty_active = pol_level(dirty_in_s, pol_dirty_in);
  wire valid_active = pol_level(tv_s, pol_tag_valid);

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_busy <= lcm_pkg::RST_BIT;
      beat_done <= lcm_pkg::RST_BIT;
      l2_hit <= lcm_pkg::RST_BIT;
      l2_dirty <= lcm_pkg::RST_BIT;
      l2_line_valid <= lcm_pkg::RST_BIT;
      ext_claim <= lcm_pkg::RST_BIT;
      ext_cache_bus_req <= lcm_pkg::RST_BIT;
      cpu_bus_req <= lcm_pkg::RST_TRIPLE;
    end else if (ce) begin
      acc_busy <= (state_nxt != lcm_pkg::ST_IDLE);
      beat_done <= in_beat;
      l2_hit <= mode_int & hit_active;
      l2_dirty <= mode_int & dirty_active;
      l2_line_valid <= mode_int & ~tv_pin_oe & valid_active;
      ext_claim <= mode_ext & hit_active;
      ext_cache_bus_req <= mode_ext & strobe_s;
      cpu_bus_req <= mode_mp ? {count0_s, tv_s, dirty_in_s} : lcm_pkg::RST_TRIPLE;
    end
  end

endmodule : lcm_pin_group

// >>> sim/lcm_pin_chk.sv
/* Checker on the pin group ports.
   Assumes ce drops only while idle in mode 0. */
`timescale 1ns/10ps
module lcm_pin_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] mode_sel,
  input wire logic acc_busy,
  input wire logic beat_done,
  input wire logic strobe_pin_o,
  input wire logic strobe_pin_oe,
  input wire logic count0_pin_oe,
  input wire logic step_pin_o,
  input wire logic select_pin_o,
  input wire logic dirty_out_pin_o,
  input wire logic doe_pin_o,
  input wire logic [2:0] dwe_pin_o,
  input wire logic toe_pin_o,
  input wire logic tv_pin_oe,
  input wire logic twe_pin_o,
  input wire logic ext_addr_grant_give,
  input wire logic ext_data_grant_give,
  input wire logic [2:0] cpu_addr_grant_give,
  input wire logic [2:0] cpu_data_grant_give
);
  // ----
  // settled mode
  // ----
  logic [1:0] mode_r;
  logic run_r;
  wire st = run_r && mode_r == mode_sel;
  wire m0 = st && mode_sel == lcm_pkg::MODE_INT;
  always_ff @(posedge clk) begin
    mode_r <= mode_sel;
    run_r <= !reset;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  chk_strobe_start: assert property ($rose(acc_busy) && m0 |=> strobe_pin_o && select_pin_o)
    else $error("no strobe");
  chk_strobe_once: assert property (m0 && strobe_pin_o |=> !strobe_pin_o)
    else $error("strobe width");
  chk_select_beat: assert property (m0 && beat_done |-> select_pin_o)
    else $error("select off");
  chk_doe_read: assert property (m0 && doe_pin_o |-> beat_done && dwe_pin_o == 3'h0)
    else $error("doe stray");
  chk_dwe_triple: assert property (m0 |-> dwe_pin_o inside {3'h0, 3'h7})
    else $error("dwe split");
  chk_tv_twe: assert property (m0 && tv_pin_oe |-> twe_pin_o)
    else $error("tv without twe");
  chk_ext_agrant: assert property (st && mode_sel[0] |-> step_pin_o == $past(ext_addr_grant_give))
    else $error("ext addr grant");
  chk_ext_dgrant: assert property (st && mode_sel[0] |-> doe_pin_o == $past(ext_data_grant_give))
    else $error("ext data grant");
  chk_ext_dir: assert property (st && mode_sel[0] |-> !strobe_pin_oe)
    else $error("ext pin driven");
  chk_cpu_agrant: assert property (st && mode_sel[1] |->
    {select_pin_o, twe_pin_o, dirty_out_pin_o} == $past(cpu_addr_grant_give))
    else $error("cpu addr grant");
  chk_cpu_dgrant: assert property (st && mode_sel[1] |->
    {dwe_pin_o[1:0], toe_pin_o} == $past(cpu_data_grant_give))
    else $error("cpu data grant");
  chk_mp_dir: assert property (st && mode_sel[1] |-> !count0_pin_oe && !tv_pin_oe)
    else $error("mp pin driven");
endmodule : lcm_pin_chk

// >>> sim/lcm_far_model.sv
/* Far side: tag RAM, external controller, extra processors.
   Assumes levels come from the bench. */
`timescale 1ns/10ps
module lcm_far_model (
  input wire logic strobe_pin_o,
  input wire logic strobe_pin_oe,
  input wire logic count0_pin_o,
  input wire logic count0_pin_oe,
  input wire logic tv_pin_o,
  input wire logic tv_pin_oe,
  input wire logic hit_lvl,
  input wire logic dirty_lvl,
  input wire logic tv_lvl,
  input wire logic strobe_lvl,
  input wire logic count0_lvl,
  output logic strobe_pin_i,
  output logic count0_pin_i,
  output logic tv_pin_i,
  output logic hit_pin_i,
  output logic dirty_in_pin_i
);
  assign hit_pin_i = hit_lvl;
  assign dirty_in_pin_i = dirty_lvl;
  assign strobe_pin_i = strobe_pin_oe ? strobe_pin_o : strobe_lvl;
  assign count0_pin_i = count0_pin_oe ? count0_pin_o : count0_lvl;
  assign tv_pin_i = tv_pin_oe ? tv_pin_o : tv_lvl;
endmodule : lcm_far_model

// >>> sim/testbench.sv
/* Bench for the pin group with far-side model.
   Assumes 40 MHz clock; ce dropped once while idle. */
`timescale 1ns/10ps
module testbench;
  logic clk = 1'h0, reset = 1'h1, ce = 1'h1, sram_is_burst = 1'h0;
  logic [1:0] mode_sel = 2'h0;
  logic pol_dirty_in = 1'h1, pol_dirty_out = 1'h1, pol_hit = 1'h1, pol_tag_valid = 1'h1;
  logic acc_start = 1'h0, acc_write = 1'h0, acc_burst = 1'h0, tag_read = 1'h0;
  logic tag_update = 1'h0, tag_set_valid = 1'h0, tag_set_dirty = 1'h0;
  logic ext_addr_grant_give = 1'h0, ext_data_grant_give = 1'h0;
  logic [2:0] cpu_addr_grant_give = 3'h0, cpu_data_grant_give = 3'h0;
  logic hit_lvl = 1'h0, dirty_lvl = 1'h0, tv_lvl = 1'h0, strobe_lvl = 1'h0, count0_lvl = 1'h0;
  logic acc_busy, beat_done, l2_hit, l2_dirty, l2_line_valid, ext_claim, ext_cache_bus_req;
  logic [2:0] cpu_bus_req, dwe_pin_o;
  logic strobe_pin_o, strobe_pin_oe, strobe_pin_i, count0_pin_o, count0_pin_oe, count0_pin_i;
  logic step_pin_o, select_pin_o, dirty_in_pin_i, dirty_out_pin_o, doe_pin_o, hit_pin_i;
  logic toe_pin_o, tv_pin_o, tv_pin_oe, tv_pin_i, twe_pin_o;
  int num_errors = 0, comparisons = 0;
  logic [31:0] r;
  lcm_pin_group lcm_pin_group_i (.*);
  lcm_far_model lcm_far_model_i (.*);
  always #12.5 clk = ~clk;
  // ----
  // helpers
  // ----
  function automatic logic act(logic pol, logic v);
    return pol ? v : !v;
  endfunction : act
  function automatic logic adv(int i, int n);
    return sram_is_burst ? i != n - 1 : i[1];
  endfunction : adv
  task automatic check(string what, logic [2:0] seen, logic [2:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic access(logic wr, logic bu);
    int n;
    n = bu ? 4 : 1;
    acc_write = wr;
    acc_burst = bu;
    acc_start = 1'h1;
    step(1);
    acc_start = 1'h0;
    step(1);
    check("strobe", {acc_busy, strobe_pin_o, select_pin_o}, 3'h7);
    for (int i = 0; i < n; i++) begin
      step(1);
      check("doe", {doe_pin_o, beat_done}, {!wr, 1'h1});
      check("dwe", dwe_pin_o, wr ? 3'h7 : 3'h0);
      check("step", step_pin_o, adv(i, n));
      check("count0", count0_pin_o, sram_is_burst ? 1'h0 : i[0]);
      check("strobe low", strobe_pin_o, 1'h0);
    end
    step(1);
    check("idle", {acc_busy, select_pin_o, beat_done}, 3'h0);
  endtask : access
  task automatic tag(logic v, logic d);
    tag_set_valid = v;
    tag_set_dirty = d;
    tag_update = 1'h1;
    step(1);
    tag_update = 1'h0;
    step(1);
    check("twe", {twe_pin_o, tv_pin_oe}, 3'h3);
    check("tv", tv_pin_o, act(pol_tag_valid, v));
    check("dirty out", dirty_out_pin_o, act(pol_dirty_out, d));
    step(1);
    check("twe off", {twe_pin_o, dirty_out_pin_o}, {1'h0, !pol_dirty_out});
  endtask : tag
  task automatic decode(logic [2:0] v);
    {hit_lvl, dirty_lvl, tv_lvl} = v;
    tag_read = v[0];
    step(4);
    check("hit", l2_hit, act(pol_hit, v[2]));
    check("dirty", l2_dirty, act(pol_dirty_in, v[1]));
    check("valid", l2_line_valid, act(pol_tag_valid, v[0]));
    check("toe", toe_pin_o, v[0]);
    tag_read = 1'h0;
  endtask : decode
  // ----
  // sequence
  // ----
  initial begin
    r = $urandom(32'hBDC2);
    repeat (12) @(posedge clk);
    #2;
    reset = 1'h0;
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      {pol_hit, pol_dirty_in, pol_dirty_out, pol_tag_valid} = r[3:0];
      sram_is_burst = k[2];
      access(k[0], k[1]);
      tag(r[4], r[5]);
      decode(r[8:6]);
    end
    $display("test internal done");
    ce = 1'h0;
    acc_start = 1'h1;
    tag_update = 1'h1;
    hit_lvl = !hit_lvl;
    step(3);
    check("frozen", {acc_busy, twe_pin_o, strobe_pin_o}, 3'h0);
    check("held hit", l2_hit, act(pol_hit, !hit_lvl));
    {ce, acc_start, tag_update} = 3'h4;
    step(2);
    check("thawed", {acc_busy, twe_pin_o, beat_done}, 3'h0);
    $display("test clock enable done");
    for (int m = 1; m < 4; m++) begin
      mode_sel = m[1:0];
      repeat (6) begin
        r = $urandom;
        {count0_lvl, tv_lvl, dirty_lvl, strobe_lvl, hit_lvl} = r[4:0];
        {cpu_data_grant_give, cpu_addr_grant_give} = r[10:5];
        {ext_data_grant_give, ext_addr_grant_give} = r[12:11];
        acc_start = r[13];
        step(4);
        acc_start = 1'h0;
        check("busy", acc_busy, 1'h0);
        if (m[0]) begin
          check("ext req", {ext_cache_bus_req, strobe_pin_oe}, {r[1], 1'h0});
          check("ext grant", {step_pin_o, doe_pin_o}, {r[11], r[12]});
          check("claim", ext_claim, act(pol_hit, r[0]));
        end
        if (m[1]) begin
          check("cpu req", cpu_bus_req, r[4:2]);
          check("cpu agrant", {select_pin_o, twe_pin_o, dirty_out_pin_o}, r[7:5]);
          check("cpu dgrant", {dwe_pin_o[1:0], toe_pin_o}, r[10:8]);
          check("mp dir", {count0_pin_oe, tv_pin_oe}, 3'h0);
        end
      end
      $display("test mode %0d done", m);
    end
    reset = 1'h1;
    step(2);
    check("reset pins", {step_pin_o, doe_pin_o, select_pin_o}, 3'h0);
    check("reset req", cpu_bus_req, 3'h0);
    reset = 1'h0;
    step(1);
    check("rst grant", {select_pin_o, twe_pin_o, dirty_out_pin_o}, cpu_addr_grant_give);
    check("rst dir", {strobe_pin_oe, count0_pin_oe, step_pin_o}, {2'h0, ext_addr_grant_give});
    $display("test reset done");
    complete_run();
  end
  initial begin
    #50000;
    num_errors++;
    complete_run();
  end
endmodule : testbench
bind lcm_pin_group lcm_pin_chk lcm_pin_chk_i (.*);
